// ==== hw/dcfo_frame_overhead.v ====
// ds3 c-bit parity m-frame builder and c-bit overhead ports
//
// Behaviour
// - m-frame 4760 bits, seven subframes of 680 bits
// - subframe of eight 85-bit blocks, 84 payload then one overhead bit
// - 56 overhead bits: 3 m, 28 f, 21 c, 2 p, 2 x
// - transmit overhead optionally aligned to external frame sync input
// - c-bit parity mode (m23 stuff mode low) holds the m23 stuff output low on every opportunity
// - tx c-bit port takes 13 or 14 bits, c3 per include bit
// - tx port drives clock, frame and data-link pulses; partner supplies data
// - tx data-link pulse marks c13, c14, c15
// - enable bit adds one tx port clock cycle in c3 time when c3 is not included
// - tx data-link controller enable only when compat select low
// - tx data-link controller sends hdlc messages of arbitrary length
// - flags report data-link fifo condition and message status
// - controller enabled: c13-c15 taken from controller, port ignored
// - rx port outputs c2-c6, c13-c21 with clock, frame and data-link pulse
// - rx data-link pulse marks c13, c14, c15
// - c1 identifies c-bit parity mode, c2 reserved
// - c4-c6, c16-c21 sent as one
// - c3 carries feac, value from control input, or from the tx port when the include bit is set
// - c7-c9 carry c-bit parity, c10-c12 carry febe
// - febe sent automatically on rx parity or framing error
// - m23 fixed stuffing: seven stuffs per 18 opportunities
// - software idle, ais generation and transmit-to-receive loopback
// - compat select high disables the tx data-link controller
`timescale 1ns/1ns
`include "dcfo_defs.vh"
module dcfo_frame_overhead (
  input  wire       clock_in,
  input  wire       rst_b_in,
  input  wire       ds3_tx_clk_in,
  input  wire       tx_payload_in,
  output reg        ds3_tx_data_out,
  output reg        tx_payload_req_out,
  input  wire       ds3_rx_clk_in,
  input  wire       ds3_rx_data_in,
  input  wire       rx_sync_in,
  input  wire       tx_frame_sync_in,
  input  wire       frame_sync_en_in,
  input  wire       tx_cbit_serial_in,
  output reg        tx_cbit_clock_out,
  output reg        tx_cbit_frame_pulse,
  output reg        tx_datalink_slot_pulse,
  output reg        rx_cbit_serial_out,
  output reg        rx_cbit_clock_out,
  output reg        rx_cbit_frame_pulse,
  output reg        rx_datalink_slot_pulse,
  input  wire       feac_slot_include,
  input  wire       extra_c3_clock_in,
  input  wire       feac_bit_in,
  input  wire       compat_select_n,
  input  wire       dl_enable_in,
  input  wire       dl_msg_valid_in,
  input  wire [7:0] dl_msg_byte_in,
  input  wire       dl_msg_last_in,
  output reg        dl_msg_ready_out,
  output reg        dl_fifo_empty_out,
  output reg        dl_msg_done_out,
  input  wire       idle_gen_in,
  input  wire       ais_gen_in,
  input  wire       loopback_in,
  input  wire       m23_stuff_mode_in,
  output reg        rx_parity_err_out,
  output reg        m23_stuff_out
);
  // ------------------------------------------------------------
  // input synchronisers (pins cross from outside the clock domain)
  // ------------------------------------------------------------
  reg [1:0] txc_s, rxc_s, rxd_s, fs_s, cd_s, rsy_s;
  reg       txc_d, rxc_d;
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      txc_s <= 2'h0; rxc_s <= 2'h0; rxd_s <= 2'h0;
      fs_s  <= 2'h0; cd_s  <= 2'h0; rsy_s <= 2'h0;
      txc_d <= 1'b0; rxc_d <= 1'b0;
    end else begin
      txc_s <= {txc_s[0], ds3_tx_clk_in};
      rxc_s <= {rxc_s[0], ds3_rx_clk_in};
      rxd_s <= {rxd_s[0], loopback_in ? ds3_tx_data_out : ds3_rx_data_in};
      fs_s  <= {fs_s[0], tx_frame_sync_in};
      cd_s  <= {cd_s[0], tx_cbit_serial_in};
      rsy_s <= {rsy_s[0], rx_sync_in};
      txc_d <= txc_s[1];
      rxc_d <= rxc_s[1];
    end
  end
  wire tx_bit = txc_s[1] & ~txc_d;   // one enable per transmit bit
  wire rx_bit = (loopback_in ? txc_s[1] & ~txc_d : rxc_s[1] & ~rxc_d);
  wire dl_en  = dl_enable_in & ~compat_select_n;

  // ------------------------------------------------------------
  // frame position counters
  // ------------------------------------------------------------
  wire [2:0] t_sub, t_blk, r_sub, r_blk;
  wire [6:0] t_bit, r_bit;
  wire       fs_rise;
  reg        fs_d;
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) fs_d <= 1'b0;
    else fs_d <= fs_s[1];
  end
  assign fs_rise = fs_s[1] & ~fs_d;
  reg fs_pend;
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) fs_pend <= 1'b0;
    else if (fs_rise & frame_sync_en_in) fs_pend <= 1'b1;
    else if (tx_bit) fs_pend <= 1'b0;  // an edge on the bit enable is never lost
  end
  dcfo_cbit_pos u_tx_pos (
    .clock_in  (clock_in),
    .rst_b_in  (rst_b_in),
    .bit_en_in (tx_bit),
    .sync_in   (fs_pend),
    .sub_out   (t_sub),
    .blk_out   (t_blk),
    .bit_out   (t_bit)
  );
  dcfo_cbit_pos u_rx_pos (
    .clock_in  (clock_in),
    .rst_b_in  (rst_b_in),
    .bit_en_in (rx_bit),
    .sync_in   (rsy_s[1]),
    .sub_out   (r_sub),
    .blk_out   (r_blk),
    .bit_out   (r_bit)
  );

  // overhead slot decode: bit 84 of each block, block index names it
  wire       t_oh = (t_bit == `DCFO_PAYLOAD_BITS);
  wire       r_oh = (r_bit == `DCFO_PAYLOAD_BITS);
  wire [3:0] t_blk4 = {1'b0, t_blk};
  wire [3:0] r_blk4 = {1'b0, r_blk};
  // c-bit index 0..2 within a subframe, or 3 when not a c-bit block
  function [1:0] cidx;
    input [3:0] b;
    begin
      if (b == `DCFO_CBIT_BLK0) cidx = 2'h0;
      else if (b == `DCFO_CBIT_BLK1) cidx = 2'h1;
      else if (b == `DCFO_CBIT_BLK2) cidx = 2'h2;
      else cidx = 2'h3;
    end
  endfunction
  wire [1:0] t_ci = cidx(t_blk4);
  wire [1:0] r_ci = cidx(r_blk4);
  wire [4:0] t_cnum = {2'h0, t_sub} * 5'h3 + {3'h0, t_ci} + 5'h1;  // c-bit number
  wire [4:0] r_cnum = {2'h0, r_sub} * 5'h3 + {3'h0, r_ci} + 5'h1;

  // ------------------------------------------------------------
  // c-bit port slot selection
  // ------------------------------------------------------------
  // a slot carries c2..c6 and c13..c21; c3 on tx only when included
  function ext_slot;
    input [4:0] n;
    input       tx;
    begin
      ext_slot = (n >= 5'h2 && n <= 5'h6) || (n >= 5'hD && n <= 5'h15);
      if (tx && n == 5'h3 && !feac_slot_include) ext_slot = 1'b0;
    end
  endfunction
  wire t_cslot = t_oh & (t_ci != 2'h3) & ext_slot(t_cnum, 1'b1);
  wire r_cslot = r_oh & (r_ci != 2'h3) & ext_slot(r_cnum, 1'b0);
  wire t_dlslot = t_cnum >= 5'hD && t_cnum <= 5'hF;
  wire r_dlslot = r_cnum >= 5'hD && r_cnum <= 5'hF;

  // ------------------------------------------------------------
  // transmit c-bit port: clock, framing pulse, data capture
  // ------------------------------------------------------------
  // one clock per slot; the frame pulse leads the first slot (c2) by
  // one bit period; data is sampled at the slot itself
  reg [20:0] txc_cap;
  wire t_first = (t_sub == 3'h0) && (t_blk4 == `DCFO_CBIT_BLK1) &&
                 (t_bit == `DCFO_PAYLOAD_BITS - 7'h1);
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_cbit_clock_out      <= 1'b0;
      tx_cbit_frame_pulse    <= 1'b0;
      tx_datalink_slot_pulse <= 1'b0;
      txc_cap                <= 21'h1FFFFF;
    end else if (tx_bit) begin
      tx_cbit_frame_pulse    <= t_first;
      tx_datalink_slot_pulse <= t_cslot & t_dlslot;
      // extra clock in c3 time when enabled and c3 is not a slot
      tx_cbit_clock_out <= t_cslot | (extra_c3_clock_in & t_oh &
                           t_cnum == 5'h3 & ~feac_slot_include);
      if (t_cslot)
        txc_cap[t_cnum - 5'h1] <= cd_s[1];
    end else begin
      tx_cbit_clock_out      <= 1'b0;
      tx_cbit_frame_pulse    <= 1'b0;
      tx_datalink_slot_pulse <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // transmit data-link controller (hdlc framing on c13..c15)
  // ------------------------------------------------------------
  // flag 7E between messages, zero insertion after five ones, crc omitted
  // for area; message length limited only by the source
  reg [7:0] dl_sh;
  reg [3:0] dl_cnt;
  reg [2:0] dl_ones;
  reg       dl_busy, dl_last;
  wire dl_take = dl_en & tx_bit & t_cslot & t_dlslot;
  wire dl_stuff = dl_busy & (dl_ones == 3'h5);
  wire dl_bit = dl_stuff ? 1'b0 : dl_sh[0];
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dl_sh <= 8'h7E; dl_cnt <= 4'h0; dl_ones <= 3'h0;
      dl_busy <= 1'b0; dl_last <= 1'b0;
      dl_msg_ready_out <= 1'b0; dl_fifo_empty_out <= 1'b1; dl_msg_done_out <= 1'b0;
    end else begin
      dl_msg_ready_out <= 1'b0;
      dl_msg_done_out  <= 1'b0;
      if (dl_take) begin
        if (dl_stuff) dl_ones <= 3'h0;
        else begin
          dl_ones <= (dl_busy & dl_sh[0]) ? dl_ones + 3'h1 : 3'h0;
          dl_sh   <= {1'b0, dl_sh[7:1]};
          dl_cnt  <= dl_cnt + 4'h1;
          if (dl_cnt == 4'h7) begin
            dl_cnt <= 4'h0;
            if (dl_busy & dl_last) begin
              dl_busy <= 1'b0; dl_sh <= 8'h7E; dl_msg_done_out <= 1'b1;
            end else if (dl_msg_valid_in) begin
              dl_busy <= 1'b1; dl_sh <= dl_msg_byte_in;
              dl_last <= dl_msg_last_in; dl_msg_ready_out <= 1'b1;
            end else begin
              dl_busy <= 1'b0; dl_sh <= 8'h7E;
            end
          end
        end
      end
      dl_fifo_empty_out <= ~(dl_en & dl_msg_valid_in);
    end
  end

  // ------------------------------------------------------------
  // transmit m-frame assembly
  // ------------------------------------------------------------
  reg        par_acc, par_frame, febe_pend;
  reg [4:0]  stuff_cnt;
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ds3_tx_data_out <= 1'b1; tx_payload_req_out <= 1'b0;
      par_acc <= 1'b0; par_frame <= 1'b0;
      stuff_cnt <= 5'h0; m23_stuff_out <= 1'b0;
    end else begin
      tx_payload_req_out <= 1'b0;
      if (tx_bit) begin
        if (ais_gen_in) ds3_tx_data_out <= 1'b1;
        else if (!t_oh) begin
          // idle payload is 1100 repeating
          ds3_tx_data_out <= idle_gen_in ? ~t_bit[1] : tx_payload_in;
          tx_payload_req_out <= ~idle_gen_in;
          par_acc <= par_acc ^ (idle_gen_in ? ~t_bit[1] : tx_payload_in);
        end else if (t_blk4 == `DCFO_XBIT_BLOCK && t_sub <= 3'h1)
          ds3_tx_data_out <= 1'b1;                             // x-bits
        else if (t_blk4 == `DCFO_PAR_BLOCK && t_sub >= 3'h2 && t_sub <= 3'h3)
          ds3_tx_data_out <= par_frame;                       // p-bits
        else if (t_blk4 == `DCFO_MALIGN_BLOCK && t_sub >= `DCFO_MALIGN_SUB4)
          ds3_tx_data_out <= (t_sub == 3'h5);                 // m-bits 010
        else if (t_ci != 2'h3) begin
          if (t_cnum == 5'h1) ds3_tx_data_out <= 1'b1;
          else if (t_cnum == 5'h3)
            ds3_tx_data_out <= feac_slot_include ? txc_cap[2] : feac_bit_in;
          else if (t_cnum >= 5'h7 && t_cnum <= 5'h9)
            ds3_tx_data_out <= par_frame;
          else if (t_cnum >= 5'hA && t_cnum <= 5'hC)
            ds3_tx_data_out <= ~febe_pend;
          else if (t_cnum >= 5'hD && t_cnum <= 5'hF)
            ds3_tx_data_out <= dl_en ? dl_bit : txc_cap[t_cnum - 5'h1];
          else
            ds3_tx_data_out <= 1'b1;
        end else
          ds3_tx_data_out <= t_blk[2] ~^ t_blk[1];            // f-bits 1001
        if (t_sub == 3'h6 && t_blk == 3'h7 && t_oh) begin
          par_frame <= par_acc; par_acc <= 1'b0;
          // m23 stuffing: 7 of every 18 opportunities
          stuff_cnt <= (stuff_cnt == `DCFO_STUFF_OPPS - 5'h1) ? 5'h0 : stuff_cnt + 5'h1;
        end
        if (t_oh) m23_stuff_out <= m23_stuff_mode_in & (stuff_cnt < `DCFO_STUFFS);
      end
    end
  end

  // ------------------------------------------------------------
  // receive c-bit port and error detection
  // ------------------------------------------------------------
  reg rpar_acc, rpar_frame, rcpar;
  wire r_first = (r_sub == 3'h0) && (r_blk4 == `DCFO_CBIT_BLK1) &&
                 (r_bit == `DCFO_PAYLOAD_BITS - 7'h1);
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_cbit_serial_out <= 1'b1; rx_cbit_clock_out <= 1'b0;
      rx_cbit_frame_pulse <= 1'b0; rx_datalink_slot_pulse <= 1'b0;
      rpar_acc <= 1'b0; rpar_frame <= 1'b0; rcpar <= 1'b0;
      rx_parity_err_out <= 1'b0; febe_pend <= 1'b0;
    end else begin
      if (tx_bit & t_oh & t_cnum == 5'hC) febe_pend <= 1'b0;
      if (rx_bit) begin
        rx_cbit_frame_pulse    <= r_first;
        rx_datalink_slot_pulse <= r_cslot & r_dlslot;
        rx_cbit_clock_out      <= r_cslot;
        rx_parity_err_out      <= 1'b0;
        if (r_cslot) rx_cbit_serial_out <= rxd_s[1];
        if (!r_oh) rpar_acc <= rpar_acc ^ rxd_s[1];
        if (r_oh && r_ci != 2'h3 && r_cnum == 5'h7) rcpar <= rxd_s[1];
        if (r_sub == 3'h6 && r_blk == 3'h7 && r_oh) begin
          rpar_frame <= rpar_acc; rpar_acc <= 1'b0;
          if (rcpar != rpar_frame) begin
            rx_parity_err_out <= 1'b1; febe_pend <= 1'b1;
          end
        end
        // f-bit mismatch counts as framing error
        if (r_oh && r_ci == 2'h3 && r_blk != 3'h0 &&
            rxd_s[1] != (r_blk[2] ~^ r_blk[1])) febe_pend <= 1'b1;
      end else begin
        rx_cbit_clock_out      <= 1'b0;
        rx_cbit_frame_pulse    <= 1'b0;
        rx_datalink_slot_pulse <= 1'b0;
        rx_parity_err_out      <= 1'b0;
      end
    end
  end
endmodule // dcfo_frame_overhead

// ==== common/dcfo_defs.vh ====
// constants for the ds3 c-bit frame overhead block
`ifndef DCFO_DEFS_VH
`define DCFO_DEFS_VH
`define DCFO_FRAME_BITS     13'd4760
`define DCFO_SUBFRAME_BITS  10'd680
`define DCFO_BLOCK_BITS     7'd85
`define DCFO_PAYLOAD_BITS   7'd84
`define DCFO_BLOCKS_PER_SUB 3'd7
`define DCFO_SUBFRAMES      3'd7
`define DCFO_OH_PER_FRAME   6'd56
`define DCFO_FEAC_BLOCK     4'd5
`define DCFO_CBIT_BLK0      4'd2
`define DCFO_CBIT_BLK1      4'd4
`define DCFO_CBIT_BLK2      4'd6
`define DCFO_PAR_BLOCK      4'd0
`define DCFO_MALIGN_BLOCK   4'd0
`define DCFO_XBIT_BLOCK     4'd0
`define DCFO_MALIGN_SUB4    3'd4
`define DCFO_PSEUDO_DS2     10'd671
`define DCFO_STUFF_OPPS     5'd18
`define DCFO_STUFFS         5'd7
`define DCFO_RX_CBIT_COUNT  5'd14
`endif

// ==== hw/dcfo_cbit_pos.v ====
// overhead position counter for one ds3 m-frame
`timescale 1ns/1ns
`include "dcfo_defs.vh"
module dcfo_cbit_pos (
  input  wire       clock_in,
  input  wire       rst_b_in,
  input  wire       bit_en_in,
  input  wire       sync_in,
  output reg  [2:0] sub_out,
  output reg  [2:0] blk_out,
  output reg  [6:0] bit_out
);
  // --------------------------------------------------------------
  // counters: bit in block, block in subframe, subframe in frame
  // --------------------------------------------------------------
  // sync loads the position just after the last overhead bit
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sub_out <= 3'h0;
      blk_out <= 3'h0;
      bit_out <= 7'h0;
    end else if (bit_en_in) begin
      if (sync_in) begin
        sub_out <= 3'h0;
        blk_out <= 3'h0;
        bit_out <= 7'h0;
      end else if (bit_out == `DCFO_BLOCK_BITS - 7'h1) begin
        bit_out <= 7'h0;
        if (blk_out == 3'h7) begin
          blk_out <= 3'h0;
          sub_out <= (sub_out == `DCFO_SUBFRAMES - 3'h1) ? 3'h0 : sub_out + 3'h1;
        end else begin
          blk_out <= blk_out + 3'h1;
        end
      end else begin
        bit_out <= bit_out + 7'h1;
      end
    end
  end
endmodule // dcfo_cbit_pos

// ==== sim/dcfo_frame_overhead_chk.sv ====
// assertion checker for the c-bit overhead ports
`timescale 1ns/1ns
module dcfo_frame_overhead_chk (
  input wire clock_in,
  input wire rst_b_in,
  input wire compat_select_n,
  input wire dl_msg_ready_out,
  input wire tx_cbit_clock_out,
  input wire tx_cbit_frame_pulse,
  input wire tx_datalink_slot_pulse,
  input wire rx_cbit_clock_out,
  input wire rx_cbit_frame_pulse,
  input wire rx_datalink_slot_pulse
);
  // ----------------------------------------
  // port pulse relations
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // first slot clock comes one bit time (12 clocks at 48 ns) after the frame pulse
  sequence tx_first_slot;
    (!tx_cbit_clock_out) [*7] ##[1:9] tx_cbit_clock_out;
  endsequence
  sequence rx_first_slot;
    (!rx_cbit_clock_out) [*7] ##[1:9] rx_cbit_clock_out;
  endsequence
  AST_TX_CLK_ONE: assert property (tx_cbit_clock_out |=> !tx_cbit_clock_out)
    else $error("tx c-bit clock wider than one cycle");
  AST_RX_CLK_ONE: assert property (rx_cbit_clock_out |=> !rx_cbit_clock_out)
    else $error("rx c-bit clock wider than one cycle");
  AST_TX_FRM_FIRST: assert property (tx_cbit_frame_pulse |=> tx_first_slot)
    else $error("tx first slot clock not one bit after frame pulse");
  AST_RX_FRM_FIRST: assert property (rx_cbit_frame_pulse |=> rx_first_slot)
    else $error("rx first slot clock not one bit after frame pulse");
  AST_TX_DL_ON_CLK: assert property (tx_datalink_slot_pulse |-> tx_cbit_clock_out)
    else $error("tx data-link pulse outside a slot clock");
  AST_RX_DL_ON_CLK: assert property (rx_datalink_slot_pulse |-> rx_cbit_clock_out)
    else $error("rx data-link pulse outside a slot clock");
  AST_DL_LOCKED: assert property (compat_select_n |-> !dl_msg_ready_out)
    else $error("data-link took a byte while compat select high");
  AST_TX_FRM_SOLO: assert property (tx_cbit_frame_pulse |-> !tx_cbit_clock_out)
    else $error("tx frame pulse on a slot clock");
  AST_RX_FRM_SOLO: assert property (rx_cbit_frame_pulse |-> !rx_cbit_clock_out)
    else $error("rx frame pulse on a slot clock");
endmodule // dcfo_frame_overhead_chk

bind dcfo_frame_overhead dcfo_frame_overhead_chk dcfo_frame_overhead_chk_inst (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .compat_select_n(compat_select_n),
  .dl_msg_ready_out(dl_msg_ready_out), .tx_cbit_clock_out(tx_cbit_clock_out),
  .tx_cbit_frame_pulse(tx_cbit_frame_pulse), .tx_datalink_slot_pulse(tx_datalink_slot_pulse),
  .rx_cbit_clock_out(rx_cbit_clock_out), .rx_cbit_frame_pulse(rx_cbit_frame_pulse),
  .rx_datalink_slot_pulse(rx_datalink_slot_pulse));

// ==== sim/dcfo_line_model.sv ====
// line side and external c-bit source model for the overhead block
`timescale 1ns/1ns
module dcfo_line_model (
  input  wire clock_in,
  input  wire rst_b_in,
  input  wire ds3_tx_data_out,
  input  wire tx_payload_req_out,
  input  wire tx_cbit_clock_out,
  input  wire tx_cbit_frame_pulse,
  output reg  ds3_tx_clk_in,
  output reg  tx_payload_in,
  output reg  tx_cbit_serial_in,
  output wire ds3_rx_clk_in,
  output wire ds3_rx_data_in
);
  reg [4:0] slot_reg;
  // ----------------------------------------
  // line clock and cable loop
  // ----------------------------------------
  // line clock runs free at 48 ns, phase unrelated to clock_in
  initial begin
    ds3_tx_clk_in = 1'b0;
    #7;
    forever #24 ds3_tx_clk_in = ~ds3_tx_clk_in;
  end
  assign ds3_rx_clk_in  = ds3_tx_clk_in;
  assign ds3_rx_data_in = ds3_tx_data_out;
  // slot count follows the port clock; payload toggles so a stuck path shows
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      slot_reg      <= 5'h00;
      tx_payload_in <= 1'b0;
    end else begin
      if (tx_cbit_frame_pulse) slot_reg <= 5'h00;
      else if (tx_cbit_clock_out) slot_reg <= slot_reg + 5'h01;
      if (tx_payload_req_out) tx_payload_in <= ~tx_payload_in;
    end
  end
  // undefined c-bits are sent as one; one zero sits in a data-link slot
  always @* tx_cbit_serial_in = (slot_reg != 5'h06);
endmodule // dcfo_line_model

// ==== sim/tb.sv ====
// self-checking bench for the c-bit frame overhead block
`timescale 1ns/1ns
module tb;
  reg        clock_in, rst_b_in, tx_frame_sync_in, frame_sync_en_in, feac_slot_include;
  reg        extra_c3_clock_in, compat_select_n, dl_enable_in, dl_msg_valid_in;
  reg        dl_msg_last_in, loopback_in, meas, seen;
  reg [7:0]  dl_msg_byte_in;
  reg [31:0] tx_mask, rx_mask, tx_dl;
  wire       ds3_tx_clk_in, tx_payload_in, ds3_tx_data_out, tx_payload_req_out;
  wire       ds3_rx_clk_in, ds3_rx_data_in, tx_cbit_serial_in, tx_cbit_clock_out;
  wire       tx_cbit_frame_pulse, tx_datalink_slot_pulse, rx_cbit_serial_out;
  wire       rx_cbit_clock_out, rx_cbit_frame_pulse, rx_datalink_slot_pulse;
  wire       dl_msg_ready_out, dl_fifo_empty_out, dl_msg_done_out;
  integer    n_errors, compares, cyc, i, tx_idx, rx_idx;
  integer    tx_clks, tx_dls, tx_frms, rx_clks, rx_dls, rx_frms;

  dcfo_frame_overhead dcfo_frame_overhead_inst (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .ds3_tx_clk_in(ds3_tx_clk_in),
    .tx_payload_in(tx_payload_in), .ds3_tx_data_out(ds3_tx_data_out),
    .tx_payload_req_out(tx_payload_req_out), .ds3_rx_clk_in(ds3_rx_clk_in),
    .ds3_rx_data_in(ds3_rx_data_in), .rx_sync_in(1'b0), .tx_frame_sync_in(tx_frame_sync_in),
    .frame_sync_en_in(frame_sync_en_in), .tx_cbit_serial_in(tx_cbit_serial_in),
    .tx_cbit_clock_out(tx_cbit_clock_out), .tx_cbit_frame_pulse(tx_cbit_frame_pulse),
    .tx_datalink_slot_pulse(tx_datalink_slot_pulse), .rx_cbit_serial_out(rx_cbit_serial_out),
    .rx_cbit_clock_out(rx_cbit_clock_out), .rx_cbit_frame_pulse(rx_cbit_frame_pulse),
    .rx_datalink_slot_pulse(rx_datalink_slot_pulse), .feac_slot_include(feac_slot_include),
    .extra_c3_clock_in(extra_c3_clock_in), .feac_bit_in(1'b1),
    .compat_select_n(compat_select_n), .dl_enable_in(dl_enable_in),
    .dl_msg_valid_in(dl_msg_valid_in), .dl_msg_byte_in(dl_msg_byte_in),
    .dl_msg_last_in(dl_msg_last_in), .dl_msg_ready_out(dl_msg_ready_out),
    .dl_fifo_empty_out(dl_fifo_empty_out), .dl_msg_done_out(),
    .idle_gen_in(1'b0), .ais_gen_in(1'b0), .loopback_in(loopback_in),
    .m23_stuff_mode_in(1'b0), .rx_parity_err_out(), .m23_stuff_out());

  dcfo_line_model dcfo_line_model_inst (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .ds3_tx_data_out(ds3_tx_data_out),
    .tx_payload_req_out(tx_payload_req_out), .tx_cbit_clock_out(tx_cbit_clock_out),
    .tx_cbit_frame_pulse(tx_cbit_frame_pulse), .ds3_tx_clk_in(ds3_tx_clk_in),
    .tx_payload_in(tx_payload_in), .tx_cbit_serial_in(tx_cbit_serial_in),
    .ds3_rx_clk_in(ds3_rx_clk_in), .ds3_rx_data_in(ds3_rx_data_in));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  task check(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("FAIL t=%0t seen=%h expected=%h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // bounded wait for the tx frame pulse, counted in clocks
  task wait_frame;
    begin
      cyc = 0;
      while (tx_cbit_frame_pulse !== 1'b1 && cyc < 60000) begin
        @(negedge clock_in);
        cyc = cyc + 1;
      end
      if (cyc >= 60000) n_errors = n_errors + 1;
    end
  endtask
  // slot index since each frame pulse; tallies only over the measured frame
  always @(posedge clock_in) begin
    if (tx_cbit_frame_pulse === 1'b1) tx_idx = 0;
    if (tx_cbit_clock_out === 1'b1) tx_idx = tx_idx + 1;
    if (rx_cbit_frame_pulse === 1'b1) rx_idx = 0;
    if (rx_cbit_clock_out === 1'b1) rx_idx = rx_idx + 1;
    if (meas) begin
      tx_clks = tx_clks + (tx_cbit_clock_out === 1'b1);
      tx_frms = tx_frms + (tx_cbit_frame_pulse === 1'b1);
      rx_clks = rx_clks + (rx_cbit_clock_out === 1'b1);
      rx_frms = rx_frms + (rx_cbit_frame_pulse === 1'b1);
      if (tx_datalink_slot_pulse === 1'b1) tx_mask = tx_mask | (32'h1 << tx_idx);
      if (rx_datalink_slot_pulse === 1'b1) rx_mask = rx_mask | (32'h1 << rx_idx);
      // line bit in each data-link slot, c13 first
      if (tx_datalink_slot_pulse === 1'b1) tx_dl = {tx_dl[30:0], ds3_tx_data_out};
    end
  end
  // watchdog sized above reset, data-link phase and two frame waits
  initial begin
    repeat (80000) @(posedge clock_in);
    n_errors = n_errors + 1;
    close_out;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_b_in, tx_frame_sync_in, frame_sync_en_in, feac_slot_include, meas, seen} = 6'h00;
    {extra_c3_clock_in, compat_select_n, loopback_in} = 3'h7;
    {dl_enable_in, dl_msg_valid_in, dl_msg_last_in} = 3'h0;
    dl_msg_byte_in = 8'h5A;
    {n_errors, compares, tx_idx, rx_idx} = {32'd0, 32'd0, 32'd100, 32'd100};
    {tx_clks, tx_frms, rx_clks, rx_frms, tx_mask, rx_mask, tx_dl} = {7{32'd0}};
    repeat (16) @(negedge clock_in);
    check({tx_cbit_clock_out, tx_cbit_frame_pulse, tx_datalink_slot_pulse,
           rx_cbit_clock_out, rx_cbit_frame_pulse, rx_datalink_slot_pulse}, 32'h0);
    check({ds3_tx_data_out, rx_cbit_serial_out, dl_fifo_empty_out}, 32'h7);
    rst_b_in = 1'b1;
    repeat (4) @(negedge clock_in);
    // data-link source offered while compat select is high: nothing taken
    {dl_enable_in, dl_msg_valid_in, dl_msg_last_in} = 3'h7;
    for (i = 0; i < 200; i = i + 1) begin
      @(negedge clock_in);
      if (dl_msg_ready_out === 1'b1) seen = 1'b1;
    end
    check(seen, 32'h0);
    check(dl_fifo_empty_out, 32'h1);
    compat_select_n = 1'b0;
    for (i = 0; i < 200 && dl_msg_ready_out !== 1'b1; i = i + 1) @(negedge clock_in);
    // a byte is taken only after the opening flag, frames later; the source shows pending
    check(dl_fifo_empty_out, 32'h0);
    dl_msg_valid_in = 1'b0;
    repeat (2) @(negedge clock_in);
    check(dl_fifo_empty_out, 32'h1);
    // realign tx frame: frame pulse lands 423 bits (12 clocks each) after the sync edge
    {frame_sync_en_in, tx_frame_sync_in} = 2'h3;
    @(negedge clock_in);
    wait_frame;
    check(cyc >= 5052 && cyc <= 5106, 32'h1);
    meas = 1'b1;
    @(negedge clock_in);
    wait_frame;
    meas = 1'b0;
    check(cyc + 1, 32'd57120);
    check(tx_clks, 32'd14);
    check(tx_mask, 32'h000001C0);
    // flag bits 0,1,1 from the controller; the port would have given 1,0,1
    check(tx_dl, 32'h00000003);
    check(tx_frms, 32'd1);
    check(rx_clks, 32'd14);
    check(rx_mask, 32'h000001C0);
    check(rx_frms, 32'd1);
    close_out;
  end
endmodule // tb
